// ### hw/vic_ctrl.sv
// vectored interrupt controller with mask, status and AHB-Lite access
//
// Behaviour
// R01: service only at instruction boundaries
// R02: highest-priority enabled pending request first
// R03: no interrupt taken during any service
// R04: branches and cache loops defer interrupts
// R05: pointer post-decrement instructions defer interrupts
// R06: mask bit one enables, zero masks
// R07: masked requests still latch, fire later
// R08: status shows all recognized sources
// R09: parallel data read/write clears its flags
// R10: serial data read/write clears its flags
// R11: debug data read clears debug flag
// R12: return clears timer and pin status
// R13: write one clears bits 8-4
// R14: base layout of mask and status
// R15: coprocessor variant bit layout
// R16: pins latched at clock output fall
// R17: mask change effective at next fetch
// R18: one more instruction before service
// R19: simultaneous requests served in priority turn
// R20: code and ack mark active service
// R21: requester holds until next ack rise
// R22: requester withdraws when service starts
// R23: code zero and ack low when idle
// R24: legacy plus mask enable acts as mask
// R25: pins pass two-stage synchroniser
//
// Added by the designer: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module vic_ctrl
#(
   parameter bit COPROC_VARIANT = 1'b0
)
(
   input  wire logic        clk_sys,
   input  wire logic        reset_n,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // core sequencing
   input  wire logic        instr_end,
   input  wire logic        instr_is_branch,
   input  wire logic        instr_is_cache_loop,
   input  wire logic        instr_postdec,
   input  wire logic        trap_active,
   input  wire logic        irq_return,
   input  wire logic        clock_output,
   // request sources
   input  wire logic [1:0]  ext_irq_pin,
   input  wire logic        serial_input_full,
   input  wire logic        serial_output_empty,
   input  wire logic        serial2_input_full,
   input  wire logic        serial2_output_empty,
   input  wire logic        parallel_input_irq,
   input  wire logic        parallel_output_irq,
   input  wire logic        timer_irq,
   input  wire logic        debug_port_irq,
   input  wire logic        coproc_ready_irq,
   input  wire logic        coproc_overflow_irq,
   // data register accesses that clear flags
   input  wire logic        par_data_rd,
   input  wire logic        par_data_wr,
   input  wire logic        ser_data_rd,
   input  wire logic        ser_data_wr,
   input  wire logic        ser2_data_rd,
   input  wire logic        ser2_data_wr,
   input  wire logic        debug_data_rd,
   // service indication
   output logic [3:0]       service_code_out,
   output logic             service_active_out
);
   // implemented bits of this variant
   localparam logic [15:0] IMPL = COPROC_VARIANT ? vic_pkg::COPROC_BITS
                                                 : vic_pkg::BASE_BITS; // R14 R15

   typedef struct packed {
      vic_pkg::vic_state_t fsm;
      logic [15:0]         mask;
      logic [15:0]         mask_eff;
      logic [15:0]         status;
      logic [1:0]          ext_meta;
      logic [1:0]          ext_sync;
      logic                cko_prev;
      logic [3:0]          svc_idx;
      logic [3:0]          code;
      logic                ack;
      logic                dp_valid;
      logic                dp_write;
      logic [7:0]          dp_addr;
      logic [31:0]         rdata;
   } vic_regs_t;

   vic_regs_t  st_r;
   vic_regs_t  st_nxt;
   vic_sel_if  sel ();

   vic_select u_select
   (
      .s (sel.sel)
   );

   // =========================================================
   // helpers
   // =========================================================
   function automatic logic [15:0] onehot(input logic [3:0] i);
      return 16'h0001 << i;
   endfunction

   function automatic logic addr_hit(input logic [7:0] a,
                                     input logic [7:0] r);
      return a == r;
   endfunction

   logic        addr_phase;
   logic [15:0] set_ev;
   logic [15:0] clr_ev;
   logic [15:0] w1c;
   logic        cko_fall;
   logic        boundary_ok;

   // =========================================================
   // request and clear events
   // =========================================================
   always_comb
   begin
      addr_phase = hsel & htrans[1] & hready;
      cko_fall   = st_r.cko_prev & ~clock_output;
      set_ev     = 16'h0000;
      set_ev[vic_pkg::BIT_SER_IN]   = serial_input_full;
      set_ev[vic_pkg::BIT_SER_OUT]  = serial_output_empty;
      set_ev[vic_pkg::BIT_PAR_OUT]  = parallel_output_irq;
      set_ev[vic_pkg::BIT_PAR_IN]   = parallel_input_irq;
      set_ev[vic_pkg::BIT_TIMER]    = timer_irq;
      set_ev[vic_pkg::BIT_SER2_IN]  = serial2_input_full;
      set_ev[vic_pkg::BIT_SER2_OUT] = serial2_output_empty;
      set_ev[vic_pkg::BIT_CP_RDY]   = coproc_ready_irq;
      set_ev[vic_pkg::BIT_CP_OVF]   = coproc_overflow_irq;
      set_ev[vic_pkg::BIT_DEBUG]    = debug_port_irq;
      // pins sampled only at the clock output falling edge
      set_ev[vic_pkg::BIT_EXT0] = st_r.ext_sync[0] & cko_fall; // R16
      set_ev[vic_pkg::BIT_EXT1] = st_r.ext_sync[1] & cko_fall; // R16
      // in-service return-cleared source cannot relatch until the return ends service
      if (st_r.fsm == vic_pkg::VIC_SERVICE)
      begin
         set_ev = set_ev & ~(onehot(st_r.svc_idx) & vic_pkg::RET_BITS); // R21
      end
      set_ev = set_ev & IMPL; // R14 R15

      clr_ev = 16'h0000;
      clr_ev[vic_pkg::BIT_PAR_IN]   = par_data_rd;  // R09
      clr_ev[vic_pkg::BIT_PAR_OUT]  = par_data_wr;  // R09
      clr_ev[vic_pkg::BIT_SER_IN]   = ser_data_rd;  // R10
      clr_ev[vic_pkg::BIT_SER_OUT]  = ser_data_wr;  // R10
      clr_ev[vic_pkg::BIT_SER2_IN]  = ser2_data_rd; // R10
      clr_ev[vic_pkg::BIT_SER2_OUT] = ser2_data_wr; // R10
      clr_ev[vic_pkg::BIT_DEBUG]    = debug_data_rd; // R11

      w1c = 16'h0000;
      if (st_r.dp_valid && st_r.dp_write &&
          addr_hit(st_r.dp_addr, vic_pkg::STATUS_ADDR))
      begin
         w1c = hwdata[15:0] & vic_pkg::W1C_BITS; // R13
      end
      clr_ev = clr_ev | w1c;
      if (st_r.fsm == vic_pkg::VIC_SERVICE && irq_return)
      begin
         clr_ev = clr_ev | (onehot(st_r.svc_idx) & vic_pkg::RET_BITS); // R12 R19
      end
   end

   // legacy enables never reach here, so mask alone decides the vector
   assign sel.pending = st_r.status & st_r.mask_eff & IMPL; // R06 R24

   // an instruction just ended and may be interrupted
   always_comb
   begin
      boundary_ok = instr_end; // R01
      if (instr_is_branch || instr_is_cache_loop)
      begin
         boundary_ok = 1'b0; // R04
      end
      if (instr_postdec)
      begin
         boundary_ok = 1'b0; // R05
      end
      if (trap_active)
      begin
         boundary_ok = 1'b0; // R03
      end
   end

   // =========================================================
   // next state
   // =========================================================
   always_comb
   begin
      st_nxt = st_r;

      // pin synchroniser
      st_nxt.ext_meta = ext_irq_pin;   // R25
      st_nxt.ext_sync = st_r.ext_meta; // R25
      st_nxt.cko_prev = clock_output;

      // set wins over clear; masked requests still recognized
      st_nxt.status = ((st_r.status & ~clr_ev) | set_ev) & IMPL; // R07 R08

      // mask applied from the next instruction fetch onward
      if (instr_end)
      begin
         st_nxt.mask_eff = st_r.mask; // R17
      end

      // AHB-Lite address phase capture
      st_nxt.dp_valid = addr_phase;
      st_nxt.dp_write = hwrite;
      st_nxt.dp_addr  = haddr[7:0];
      if (addr_phase && !hwrite)
      begin
         if (addr_hit(haddr[7:0], vic_pkg::MASK_ADDR))
         begin
            st_nxt.rdata = {16'h0000, st_r.mask};
         end
         else if (addr_hit(haddr[7:0], vic_pkg::STATUS_ADDR))
         begin
            st_nxt.rdata = {16'h0000, st_r.status}; // R08
         end
         else
         begin
            st_nxt.rdata = 32'h0000_0000;
         end
      end
      if (st_r.dp_valid && st_r.dp_write &&
          addr_hit(st_r.dp_addr, vic_pkg::MASK_ADDR))
      begin
         st_nxt.mask = hwdata[15:0] & IMPL; // R06
      end

      // service sequencing
      unique case (st_r.fsm)
         vic_pkg::VIC_IDLE:
         begin
            st_nxt.code = vic_pkg::CODE_NONE; // R23
            st_nxt.ack  = 1'b0;               // R23
            if (boundary_ok && sel.any)
            begin
               st_nxt.svc_idx = sel.idx; // R02 R19
               st_nxt.fsm     = vic_pkg::VIC_ACCEPT;
            end
         end
         vic_pkg::VIC_ACCEPT:
         begin
            // one more instruction runs before the routine
            if (instr_end)
            begin
               st_nxt.fsm  = vic_pkg::VIC_SERVICE; // R18
               st_nxt.code = sel.code;             // R20
               st_nxt.ack  = 1'b1;                 // R20
               if (sel.any)
               begin
                  st_nxt.svc_idx = sel.idx; // R02
               end
               else
               begin
                  st_nxt.fsm = vic_pkg::VIC_IDLE;
                  st_nxt.ack = 1'b0;
               end
            end
         end
         vic_pkg::VIC_SERVICE:
         begin
            // held for the whole routine, no nesting
            if (irq_return)
            begin
               st_nxt.fsm  = vic_pkg::VIC_IDLE; // R03
               st_nxt.code = vic_pkg::CODE_NONE; // R23
               st_nxt.ack  = 1'b0;               // R23
            end
         end
      endcase
   end

   // =========================================================
   // state register
   // =========================================================
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         st_r          <= '0;
         st_r.fsm      <= vic_pkg::VIC_IDLE;
         st_r.mask     <= vic_pkg::MASK_RESET;
         st_r.mask_eff <= vic_pkg::MASK_RESET;
         st_r.status   <= vic_pkg::STATUS_RESET;
         st_r.code     <= vic_pkg::CODE_NONE;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // =========================================================
   // outputs
   // =========================================================
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         hreadyout <= 1'b0;
         hresp     <= 1'b0;
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   assign hrdata             = st_r.rdata;
   assign service_code_out   = st_r.code; // R20
   assign service_active_out = st_r.ack;  // R20
endmodule
`default_nettype wire

// ### hw/vic_select.sv
// fixed-priority selector of the pending vectored interrupt
`timescale 1ns/10ps
`default_nettype none
module vic_select
(
   vic_sel_if.sel s
);
   // lowest priority first; later hits override earlier ones
   localparam int N = 12;
   localparam int ORDER [N] = '{vic_pkg::BIT_EXT0, vic_pkg::BIT_DEBUG,
      vic_pkg::BIT_EXT1, vic_pkg::BIT_TIMER, vic_pkg::BIT_SER2_IN,
      vic_pkg::BIT_SER2_OUT, vic_pkg::BIT_CP_RDY, vic_pkg::BIT_CP_OVF,
      vic_pkg::BIT_SER_IN, vic_pkg::BIT_SER_OUT, vic_pkg::BIT_PAR_IN,
      vic_pkg::BIT_PAR_OUT};

   function automatic logic [3:0] code_of(input int b);
      logic [3:0] c;
      c = vic_pkg::CODE_NONE;
      unique case (b)
         vic_pkg::BIT_EXT0:     c = vic_pkg::CODE_EXT0;
         vic_pkg::BIT_DEBUG:    c = vic_pkg::CODE_DEBUG;
         vic_pkg::BIT_EXT1:     c = vic_pkg::CODE_EXT1;
         vic_pkg::BIT_TIMER:    c = vic_pkg::CODE_TIMER;
         vic_pkg::BIT_SER2_IN:  c = vic_pkg::CODE_SER2_IN;
         vic_pkg::BIT_SER2_OUT: c = vic_pkg::CODE_SER2_OUT;
         vic_pkg::BIT_CP_RDY:   c = vic_pkg::CODE_CP_RDY;
         vic_pkg::BIT_CP_OVF:   c = vic_pkg::CODE_CP_OVF;
         vic_pkg::BIT_SER_IN:   c = vic_pkg::CODE_SER_IN;
         vic_pkg::BIT_SER_OUT:  c = vic_pkg::CODE_SER_OUT;
         vic_pkg::BIT_PAR_IN:   c = vic_pkg::CODE_PAR_IN;
         vic_pkg::BIT_PAR_OUT:  c = vic_pkg::CODE_PAR_OUT;
         default:               c = vic_pkg::CODE_NONE;
      endcase
      return c;
   endfunction

   always_comb
   begin
      s.any  = 1'b0;
      s.idx  = 4'h0;
      s.code = vic_pkg::CODE_NONE;
      for (int i = 0; i < N; i++)
      begin
         if (s.pending[ORDER[i]])
         begin
            s.any  = 1'b1;
            s.idx  = 4'(ORDER[i]);
            s.code = code_of(ORDER[i]);
         end
      end
   end
endmodule
`default_nettype wire

// ### pkg/vic_pkg.sv
// constants and types shared by the vectored interrupt controller
package vic_pkg;
   // register byte addresses and reset values
   localparam logic [7:0]  MASK_ADDR     = 8'h00;
   localparam logic [7:0]  STATUS_ADDR   = 8'h04;
   localparam logic [15:0] MASK_RESET    = 16'h0000;
   localparam logic [15:0] STATUS_RESET  = 16'h0000;
   // bit positions of the sources
   localparam int BIT_SER_IN   = 0;
   localparam int BIT_SER_OUT  = 1;
   localparam int BIT_PAR_OUT  = 2;
   localparam int BIT_PAR_IN   = 3;
   localparam int BIT_EXT0     = 4;
   localparam int BIT_EXT1     = 5;
   localparam int BIT_TIMER    = 8;
   localparam int BIT_SER2_IN  = 9;
   localparam int BIT_SER2_OUT = 10;
   localparam int BIT_CP_RDY   = 12;
   localparam int BIT_CP_OVF   = 13;
   localparam int BIT_DEBUG    = 15;
   // implemented bits per variant
   localparam logic [15:0] BASE_BITS   = 16'h873f;
   localparam logic [15:0] COPROC_BITS = 16'hb73f;
   // status bits cleared by writing one
   localparam logic [15:0] W1C_BITS    = 16'h0130;
   // status bits cleared by the return instruction
   localparam logic [15:0] RET_BITS    = 16'h0130;
   // service codes
   localparam logic [3:0] CODE_NONE     = 4'h0;
   localparam logic [3:0] CODE_CP_RDY   = 4'h1;
   localparam logic [3:0] CODE_EXT0     = 4'h2;
   localparam logic [3:0] CODE_CP_OVF   = 4'h2;
   localparam logic [3:0] CODE_SER_IN   = 4'h3;
   localparam logic [3:0] CODE_SER_OUT  = 4'h4;
   localparam logic [3:0] CODE_PAR_IN   = 4'h5;
   localparam logic [3:0] CODE_PAR_OUT  = 4'h6;
   localparam logic [3:0] CODE_DEBUG    = 4'h8;
   localparam logic [3:0] CODE_EXT1     = 4'h9;
   localparam logic [3:0] CODE_TIMER    = 4'hc;
   localparam logic [3:0] CODE_SER2_IN  = 4'hd;
   localparam logic [3:0] CODE_SER2_OUT = 4'he;
   // sequencer states
   typedef enum logic [1:0] {VIC_IDLE, VIC_ACCEPT, VIC_SERVICE} vic_state_t;
endpackage

// ### pkg/vic_sel_if.sv
// carrier between the controller and its priority selector
`timescale 1ns/10ps
`default_nettype none
interface vic_sel_if;
   logic [15:0] pending;
   logic        any;
   logic [3:0]  idx;
   logic [3:0]  code;
   modport ctrl (output pending, input any, input idx, input code);
   modport sel  (input pending, output any, output idx, output code);
endinterface
`default_nettype wire

// ### tb/vectored_interrupt_control_tb.sv
// self-checking bench for the vectored interrupt controller
`timescale 1ns/10ps
`default_nettype none
module vectored_interrupt_control_tb;
   logic        clk_sys = 1'b0;
   logic        reset_n = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0]  htrans = 2'b00;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0000_0000;
   logic        instr_end = 1'b0;
   logic [3:0]  fl = 4'h0;
   logic        irq_return = 1'b0;
   logic        clock_output = 1'b0;
   logic [9:0]  src = 10'h000;
   logic [6:0]  clr = 7'h00;
   logic [1:0]  fire = 2'b00;
   logic        hreadyout, hresp, service_active_out;
   logic [31:0] hrdata;
   logic [3:0]  service_code_out;
   logic [1:0]  ext_irq_pin;
   logic [31:0] cp_rdata;
   int          failures = 0;
   int          samples_checked = 0;
   int          pos [7] = '{0, 1, 2, 3, 9, 10, 15};
   always #2 clk_sys = ~clk_sys;
   always @(posedge clk_sys) clock_output <= ~clock_output;
   vic_ctrl dut
   (
      .clk_sys, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hwdata,
      .hsize(3'b010), .hready(hreadyout), .hreadyout, .hresp, .hrdata,
      .instr_end, .instr_is_branch(fl[0]), .instr_is_cache_loop(fl[1]),
      .instr_postdec(fl[2]), .trap_active(fl[3]), .irq_return,
      .clock_output, .ext_irq_pin, .serial_input_full(src[0]),
      .serial_output_empty(src[1]), .parallel_output_irq(src[2]),
      .parallel_input_irq(src[3]), .serial2_input_full(src[4]),
      .serial2_output_empty(src[5]), .debug_port_irq(src[6]),
      .timer_irq(src[7]), .coproc_ready_irq(src[8]),
      .coproc_overflow_irq(src[9]), .ser_data_rd(clr[0]),
      .ser_data_wr(clr[1]), .par_data_wr(clr[2]), .par_data_rd(clr[3]),
      .ser2_data_rd(clr[4]), .ser2_data_wr(clr[5]),
      .debug_data_rd(clr[6]), .service_code_out, .service_active_out
   );
   // coprocessor layout on the same stimulus, read data only
   vic_ctrl #(.COPROC_VARIANT(1'b1)) dut_cp
   (
      .clk_sys, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hwdata,
      .hsize(3'b010), .hready(hreadyout), .hreadyout(), .hresp(),
      .hrdata(cp_rdata), .instr_end, .instr_is_branch(fl[0]),
      .instr_is_cache_loop(fl[1]), .instr_postdec(fl[2]),
      .trap_active(fl[3]), .irq_return, .clock_output, .ext_irq_pin,
      .serial_input_full(src[0]), .serial_output_empty(src[1]),
      .parallel_output_irq(src[2]), .parallel_input_irq(src[3]),
      .serial2_input_full(src[4]), .serial2_output_empty(src[5]),
      .debug_port_irq(src[6]), .timer_irq(src[7]),
      .coproc_ready_irq(src[8]), .coproc_overflow_irq(src[9]),
      .ser_data_rd(clr[0]), .ser_data_wr(clr[1]), .par_data_wr(clr[2]),
      .par_data_rd(clr[3]), .ser2_data_rd(clr[4]),
      .ser2_data_wr(clr[5]), .debug_data_rd(clr[6]),
      .service_code_out(), .service_active_out()
   );
   vic_ext_dev u_dev
   (
      .clk_sys, .reset_n, .fire, .service_code_out, .service_active_out,
      .ext_irq_pin
   );
   // =====
   // tasks
   task test_done;
      $display("checks %0d, failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task chk(input logic [15:0] s, input logic [15:0] e);
      samples_checked++;
      if (s !== e)
      begin
         failures++;
         $display("wrong value at %0t: got %h, want %h", $time, s, e);
      end
   endtask
   task ahb(input logic w, input logic [7:0] a, input logic [15:0] d,
            output logic [15:0] q);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr  <= {24'h00_0000, a};
      @(posedge clk_sys);
      while (hreadyout !== 1'b1) @(posedge clk_sys);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= {16'h0000, d};
      @(posedge clk_sys);
      while (hreadyout !== 1'b1) @(posedge clk_sys);
      q = hrdata[15:0];
   endtask
   task rd(input logic [7:0] a, input logic [15:0] e);
      logic [15:0] q;
      ahb(1'b0, a, 16'h0000, q);
      chk(q, e);
   endtask
   task wr(input logic [7:0] a, input logic [15:0] d);
      logic [15:0] q;
      ahb(1'b1, a, d, q);
   endtask
   task instr(input logic [3:0] f);
      instr_end <= 1'b1;
      fl        <= f;
      @(posedge clk_sys);
      instr_end <= 1'b0;
      fl        <= 4'h0;
      @(posedge clk_sys);
   endtask
   task pulse(input logic [9:0] s);
      src <= s;
      @(posedge clk_sys);
      src <= 10'h000;
      @(posedge clk_sys);
   endtask
   task serve(input logic [3:0] c, input int k, input logic [1:0] rf);
      repeat (8) @(posedge clk_sys);
      instr(4'h0);
      instr(4'h0);
      #1 chk({15'h0000, service_active_out}, 16'h0001);
      chk({12'h000, service_code_out}, {12'h000, c});
      @(posedge clk_sys);
      fire <= rf;
      if (k < 7) clr[k] <= 1'b1;
      @(posedge clk_sys);
      fire <= 2'b00;
      clr  <= 7'h00;
      repeat (8) @(posedge clk_sys);
      instr(4'h0);
      #1 chk({12'h000, service_code_out}, {12'h000, c});
      @(posedge clk_sys);
      irq_return <= 1'b1;
      @(posedge clk_sys);
      irq_return <= 1'b0;
      repeat (2) @(posedge clk_sys);
      #1 chk({11'h000, service_active_out, service_code_out}, 16'h0000);
      @(posedge clk_sys);
   endtask
   // =====
   // tests
   initial
   begin
      #40000;
      failures++;
      test_done;
   end
   initial
   begin
      repeat (3) @(posedge clk_sys);
      reset_n <= 1'b1;
      repeat (2) @(posedge clk_sys);
      rd(vic_pkg::MASK_ADDR, vic_pkg::MASK_RESET);
      rd(vic_pkg::STATUS_ADDR, vic_pkg::STATUS_RESET);
      rd(8'h08, 16'h0000);
      wr(vic_pkg::MASK_ADDR, 16'hffff);
      rd(vic_pkg::MASK_ADDR, vic_pkg::BASE_BITS);
      chk(cp_rdata[15:0], vic_pkg::COPROC_BITS);
      wr(vic_pkg::MASK_ADDR, 16'h0000);
      for (int i = 0; i < 7; i++)
      begin
         pulse(10'(1 << i));
         rd(vic_pkg::STATUS_ADDR, 16'(1 << pos[i]));
         clr[i] <= 1'b1;
         @(posedge clk_sys);
         clr <= 7'h00;
         rd(vic_pkg::STATUS_ADDR, 16'h0000);
      end
      pulse(10'h380);
      rd(vic_pkg::STATUS_ADDR, 16'h0100);
      chk(cp_rdata[15:0], 16'h3100);
      repeat (3) instr(4'h0);
      #1 chk({15'h0000, service_active_out}, 16'h0000);
      @(posedge clk_sys);
      wr(vic_pkg::STATUS_ADDR, 16'h0000);
      rd(vic_pkg::STATUS_ADDR, 16'h0100);
      wr(vic_pkg::STATUS_ADDR, 16'h0100);
      rd(vic_pkg::STATUS_ADDR, 16'h0000);
      pulse(10'h080);
      wr(vic_pkg::MASK_ADDR, 16'h0100);
      instr(4'h0);
      serve(vic_pkg::CODE_TIMER, 7, 2'b00);
      rd(vic_pkg::STATUS_ADDR, 16'h0000);
      wr(vic_pkg::MASK_ADDR, 16'hffff);
      pulse(10'h080);
      for (int i = 0; i < 4; i++)
      begin
         instr(4'(1 << i));
         instr(4'(1 << i));
         #1 chk({15'h0000, service_active_out}, 16'h0000);
         @(posedge clk_sys);
      end
      serve(vic_pkg::CODE_TIMER, 7, 2'b00);
      pulse(10'h085);
      serve(vic_pkg::CODE_PAR_OUT, 2, 2'b00);
      serve(vic_pkg::CODE_SER_IN, 0, 2'b00);
      serve(vic_pkg::CODE_TIMER, 7, 2'b00);
      rd(vic_pkg::STATUS_ADDR, 16'h0000);
      pulse(10'h070);
      serve(vic_pkg::CODE_SER2_OUT, 5, 2'b00);
      serve(vic_pkg::CODE_SER2_IN, 4, 2'b00);
      serve(vic_pkg::CODE_DEBUG, 6, 2'b00);
      fire <= 2'b11;
      @(posedge clk_sys);
      fire <= 2'b00;
      serve(vic_pkg::CODE_EXT1, 7, 2'b10);
      serve(vic_pkg::CODE_EXT1, 7, 2'b00);
      serve(vic_pkg::CODE_EXT0, 7, 2'b00);
      rd(vic_pkg::STATUS_ADDR, 16'h0000);
      test_done;
   end
endmodule
bind vic_ctrl vic_ctrl_chk u_chk
(
   .clk_sys, .reset_n, .hsel, .htrans, .hwrite, .hresp, .hrdata,
   .instr_end, .instr_is_branch, .instr_is_cache_loop, .instr_postdec,
   .trap_active, .irq_return, .service_code_out, .service_active_out
);
`default_nettype wire

// ### tb/vic_ctrl_chk.sv
// port assertions for the interrupt controller
`timescale 1ns/10ps
`default_nettype none
module vic_ctrl_chk
(
   input wire logic        clk_sys,
   input wire logic        reset_n,
   input wire logic        hsel,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hresp,
   input wire logic [31:0] hrdata,
   input wire logic        instr_end,
   input wire logic        instr_is_branch,
   input wire logic        instr_is_cache_loop,
   input wire logic        instr_postdec,
   input wire logic        trap_active,
   input wire logic        irq_return,
   input wire logic [3:0]  service_code_out,
   input wire logic        service_active_out
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   logic ok1_r;
   logic ok2_r;
   logic ok_nxt;
   assign ok_nxt = !(instr_is_branch || instr_is_cache_loop
                     || instr_postdec || trap_active);
   // interruptible flags of the last two boundaries
   always_ff @(posedge clk_sys or negedge reset_n)
      if (!reset_n)
      begin
         ok1_r <= 1'b0;
         ok2_r <= 1'b0;
      end
      else if (instr_end)
      begin
         ok1_r <= ok_nxt;
         ok2_r <= ok1_r;
      end
   // =====
   // assertions
   a_idle_zero: assert property (
      !service_active_out |-> service_code_out == 4'h0)
      else $error("code not zero while idle");
   a_code_live: assert property (
      service_active_out |-> service_code_out != 4'h0)
      else $error("zero code during service");
   a_serv_hold: assert property (
      service_active_out && !irq_return && !$past(irq_return)
      |=> service_active_out && $stable(service_code_out))
      else $error("service changed before return");
   a_ret_ends: assert property (
      irq_return && service_active_out |-> ##[1:2] !service_active_out)
      else $error("service not ended by return");
   a_one_more: assert property (
      $rose(service_active_out) |-> $past(instr_end) || $past(instr_end, 2))
      else $error("service began off a boundary");
   a_bound_ok: assert property (
      $rose(service_active_out) |-> ok2_r)
      else $error("taken at a blocked boundary");
   a_bus_okay: assert property (hresp == 1'b0)
      else $error("response not okay");
   a_rd_upper: assert property (hrdata[31:16] == 16'h0000)
      else $error("upper read bits set");
   c_serve: cover property ($rose(service_active_out));
   c_ret: cover property (irq_return && service_active_out);
   c_read: cover property (hsel && htrans[1] && !hwrite);
endmodule
`default_nettype wire

// ### tb/vic_ext_dev.sv
// external requester model driving the two interrupt pins
`timescale 1ns/10ps
`default_nettype none
module vic_ext_dev
(
   input  wire logic       clk_sys,
   input  wire logic       reset_n,
   input  wire logic [1:0] fire,
   input  wire logic [3:0] service_code_out,
   input  wire logic       service_active_out,
   output logic      [1:0] ext_irq_pin
);
   logic       ack_d_r;
   logic [1:0] hit;
   logic       rise;
   assign hit[0] = service_code_out == vic_pkg::CODE_EXT0;
   assign hit[1] = service_code_out == vic_pkg::CODE_EXT1;
   assign rise = service_active_out && !ack_d_r;
   // =====
   // request held until its own acknowledge rises
   always_ff @(posedge clk_sys or negedge reset_n)
      if (!reset_n)
      begin
         ack_d_r     <= 1'b0;
         ext_irq_pin <= 2'b00;
      end
      else
      begin
         ack_d_r     <= service_active_out;
         ext_irq_pin <= fire | (ext_irq_pin & ~(hit & {2{rise}}));
      end
endmodule
`default_nettype wire
